// ===== rtl/vfd_shift_latch_driver.sv
// Overview of operation
// RULE1 - serial edge, strobe low: shift chain
// RULE2 - serial output shows last chain stage
// RULE3 - serial edge, strobe high: clear everything
// RULE4 - strobe rising edge copies chain into latch
// RULE5 - latch holds otherwise
// RULE6 - no automatic clear at power-up
// RULE7 - host keeps blanking low until loaded
// RULE8 - blanking low forces drivers low
// RULE9 - blanking and light-all high: drivers high
// RULE10 - otherwise drivers follow latch bits
// RULE11 - host strobes only after final shift
`timescale 1ns/1ps
`default_nettype none
`include "vfd_defs.svh"

module vfd_shift_latch_driver #(
    parameter int CHAIN_LEN = `CHAIN_LEN
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 serial_clk,
    input  wire logic                 serial_in,
    input  wire logic                 latch_strobe,
    input  wire logic                 blank_n,
    input  wire logic                 light_all,
    output logic                      serial_out,
    output logic [CHAIN_LEN-1:0]      driver_output
);
    import vfd_pkg::*;

    // pin synchronisers and edge history
    logic [1:0]     sclk_sync_q, sclk_sync_d;
    logic [1:0]     sdat_sync_q, sdat_sync_d;
    logic [1:0]     strb_sync_q, strb_sync_d;
    logic [1:0]     blank_sync_q, blank_sync_d;
    logic [1:0]     light_sync_q, light_sync_d;
    logic           sclk_prev_q, sclk_prev_d;
    logic           strb_prev_q, strb_prev_d;
    logic           sclk_rise, strb_rise;
    out_ctl_s       ctl;

    // pending event waiting for the buffer
    chain_ev_s      pend_q, pend_d;
    logic           pend_vld_q, pend_vld_d;
    logic           buf_in_ready;
    logic           buf_out_valid;
    logic           buf_out_ready;
    logic [3:0]     buf_out_data;
    chain_ev_s      ev;
    logic           pop;
    logic           busy_q, busy_d;

    // chain, latch and outputs
    logic [CHAIN_LEN-1:0] chain_q, chain_d;
    logic [CHAIN_LEN-1:0] latch_q, latch_d;
    logic [CHAIN_LEN-1:0] drv_q, drv_d;
    logic                 sout_q, sout_d;

    // synchroniser and edge next values; stage 0 feeds stage 1, only stage 1 is read
    always_comb begin
        sclk_sync_d  = {sclk_sync_q[0], serial_clk};
        sdat_sync_d  = {sdat_sync_q[0], serial_in};
        strb_sync_d  = {strb_sync_q[0], latch_strobe};
        blank_sync_d = {blank_sync_q[0], blank_n};
        light_sync_d = {light_sync_q[0], light_all};
        sclk_prev_d  = sclk_sync_q[1];
        strb_prev_d  = strb_sync_q[1];
    end

    // synchroniser registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync_q  <= '0;
            sdat_sync_q  <= '0;
            strb_sync_q  <= '0;
            blank_sync_q <= '0;
            light_sync_q <= '0;
            sclk_prev_q  <= 1'b0;
            strb_prev_q  <= 1'b0;
        end else begin
            sclk_sync_q  <= sclk_sync_d;
            sdat_sync_q  <= sdat_sync_d;
            strb_sync_q  <= strb_sync_d;
            blank_sync_q <= blank_sync_d;
            light_sync_q <= light_sync_d;
            sclk_prev_q  <= sclk_prev_d;
            strb_prev_q  <= strb_prev_d;
        end
    end

    // edges on synchronised levels
    assign sclk_rise     = sclk_sync_q[1] && !sclk_prev_q;
    assign strb_rise     = strb_sync_q[1] && !strb_prev_q;
    assign ctl.blank_n   = blank_sync_q[1];
    assign ctl.light_all = light_sync_q[1];

    // turn edges into events; held while the buffer is full
    always_comb begin
        pend_d     = pend_q;
        pend_vld_d = pend_vld_q;
        if (pend_vld_q && buf_in_ready) begin
            pend_vld_d = 1'b0;
        end
        if (!pend_vld_q || buf_in_ready) begin
            if (sclk_rise && strb_sync_q[1]) begin
                pend_d     = '{kind: EV_CLEAR, data: 1'b0}; // RULE3
                pend_vld_d = 1'b1;
            end else if (sclk_rise) begin
                pend_d     = '{kind: EV_SHIFT, data: sdat_sync_q[1]}; // RULE1
                pend_vld_d = 1'b1;
            end else if (strb_rise) begin
                pend_d     = '{kind: EV_LOAD, data: 1'b0}; // RULE4
                pend_vld_d = 1'b1;
            end
        end
    end

    // pending event register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q     <= '{kind: EV_SHIFT, data: 1'b0};
            pend_vld_q <= 1'b0;
        end else begin
            pend_q     <= pend_d;
            pend_vld_q <= pend_vld_d;
        end
    end

    event_buffer #(
        .WIDTH ($bits(chain_ev_s)),
        .DEPTH (`EVBUF_DEPTH)
    ) u_evbuf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (pend_vld_q),
        .in_ready  (buf_in_ready),
        .in_data   (pend_q),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // chain applies one event, then rests a cycle
    assign ev            = chain_ev_s'(buf_out_data);
    assign buf_out_ready = !busy_q;
    assign pop           = buf_out_valid && buf_out_ready;

    // chain and latch next values
    always_comb begin
        chain_d = chain_q;
        latch_d = latch_q; // RULE5
        busy_d  = pop;
        if (pop) begin
            unique case (ev.kind)
                EV_SHIFT: chain_d = {chain_q[CHAIN_LEN-2:0], ev.data}; // RULE1
                EV_CLEAR: begin
                    chain_d = '0; // RULE3
                    latch_d = '0; // RULE3
                end
                EV_LOAD:  latch_d = chain_q; // RULE4
                default:  chain_d = chain_q;
            endcase
        end
        sout_d = chain_d[CHAIN_LEN-1]; // RULE2
    end

    // output stage selection
    always_comb begin
        if (!ctl.blank_n) begin
            drv_d = '0; // RULE8
        end else if (ctl.light_all) begin
            drv_d = '1; // RULE9
        end else begin
            drv_d = latch_q; // RULE10
        end
    end

    // contents stay undefined until a clear, or shifts and a load, write them
    always_ff @(posedge core_clk) begin
        chain_q <= chain_d; // RULE6
        latch_q <= latch_d; // RULE6
    end

    // control and output registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            sout_q <= `SERIAL_OUT_RST;
            drv_q  <= {CHAIN_LEN{`DRIVER_RST}};
        end else begin
            busy_q <= busy_d;
            sout_q <= sout_d;
            drv_q  <= drv_d;
        end
    end

    assign serial_out    = sout_q;
    assign driver_output = drv_q;

    // shared sequences
    sequence s_shift_pop;
        pop && ev.kind == EV_SHIFT;
    endsequence

    sequence s_clear_edge;
        sclk_rise && strb_sync_q[1] && !pend_vld_q;
    endsequence

    // applied shift moves every stage one place
    property p_shift;
        @(posedge core_clk) disable iff (!rst_n)
        s_shift_pop |=> chain_q[0] == $past(ev.data)
            && chain_q[CHAIN_LEN-1:1] == $past(chain_q[CHAIN_LEN-2:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("chain did not shift"); // RULE1

    // cascade output takes the old stage 58
    property p_serial_out;
        @(posedge core_clk) disable iff (!rst_n)
        s_shift_pop |=> serial_out == $past(chain_q[CHAIN_LEN-2]);
    endproperty
    a_serial_out: assert property (p_serial_out) else $error("serial output wrong"); // RULE2

    // clearing edge empties chain, latch and serial output
    property p_clear;
        @(posedge core_clk) disable iff (!rst_n)
        s_clear_edge |-> ##[2:8] (chain_q == '0 && latch_q == '0 && !serial_out);
    endproperty
    a_clear: assert property (p_clear) else $error("clear edge not applied"); // RULE3

    // load copies the chain, undefined contents included
    property p_load;
        @(posedge core_clk) disable iff (!rst_n)
        pop && ev.kind == EV_LOAD |=> latch_q === $past(chain_q);
    endproperty
    a_load: assert property (p_load) else $error("latch not loaded"); // RULE4

    // latch keeps its value, even while still undefined
    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !(pop && ev.kind != EV_SHIFT) |=> latch_q === $past(latch_q);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed"); // RULE5

    // blanking wins over everything
    property p_blank;
        @(posedge core_clk) disable iff (!rst_n)
        !ctl.blank_n |=> driver_output == '0;
    endproperty
    a_blank: assert property (p_blank) else $error("drivers not blanked"); // RULE8

    // light-all wins over latch data
    property p_light;
        @(posedge core_clk) disable iff (!rst_n)
        ctl.blank_n && ctl.light_all |=> driver_output == '1;
    endproperty
    a_light: assert property (p_light) else $error("drivers not all high"); // RULE9

    // drivers show the latch otherwise
    property p_follow;
        @(posedge core_clk) disable iff (!rst_n)
        ctl.blank_n && !ctl.light_all |=> driver_output == $past(latch_q);
    endproperty
    a_follow: assert property (p_follow) else $error("drivers not following latch"); // RULE10

    // serial edge with strobe low, nothing pending
    sequence s_shift_edge;
        sclk_rise && !strb_sync_q[1] && !pend_vld_q;
    endsequence

    // strobe rise without a serial edge, nothing pending
    sequence s_load_edge;
        strb_rise && !sclk_rise && !pend_vld_q;
    endsequence

    // clear event reaching the chain
    sequence s_clear_pop;
        pop && ev.kind == EV_CLEAR;
    endsequence

    // shift edge queues a shift with the synchronised bit
    property p_shift_event;
        @(posedge core_clk) disable iff (!rst_n)
        s_shift_edge |=> pend_vld_q && pend_q.kind == EV_SHIFT && pend_q.data == $past(sdat_sync_q[1]);
    endproperty
    a_shift_event: assert property (p_shift_event) else $error("shift edge not queued"); // RULE1

    // strobe rise queues a load
    property p_load_event;
        @(posedge core_clk) disable iff (!rst_n)
        s_load_edge |=> pend_vld_q && pend_q.kind == EV_LOAD;
    endproperty
    a_load_event: assert property (p_load_event) else $error("strobe rise not queued"); // RULE4

    // applied clear zeroes chain, latch and serial output next cycle
    property p_clear_apply;
        @(posedge core_clk) disable iff (!rst_n)
        s_clear_pop |=> chain_q == '0 && latch_q == '0 && serial_out == 1'b0;
    endproperty
    a_clear_apply: assert property (p_clear_apply) else $error("clear event not applied"); // RULE3

    // chain only moves when an event is applied
    property p_chain_idle;
        @(posedge core_clk) disable iff (!rst_n)
        !pop |=> chain_q === $past(chain_q);
    endproperty
    a_chain_idle: assert property (p_chain_idle) else $error("chain moved without event"); // RULE1

    // cascade output tracks the last stage after every event
    property p_sout_track;
        @(posedge core_clk) disable iff (!rst_n)
        pop |=> serial_out === chain_q[CHAIN_LEN-1];
    endproperty
    a_sout_track: assert property (p_sout_track) else $error("serial output off last stage"); // RULE2

endmodule : vfd_shift_latch_driver

`default_nettype wire

// ===== rtl/vfd_defs.svh
`ifndef VFD_DEFS_SVH
`define VFD_DEFS_SVH

// length of the shift chain and of the latch
`define CHAIN_LEN 60
// entries of the event buffer
`define EVBUF_DEPTH 2
// reset level of the serial output and of every driver output
`define SERIAL_OUT_RST 1'b0
`define DRIVER_RST 1'b0

`endif

// ===== rtl/vfd_pkg.sv
package vfd_pkg;

    // one-hot kinds of chain events
    typedef enum logic [2:0] {
        EV_SHIFT = 3'b001,
        EV_CLEAR = 3'b010,
        EV_LOAD  = 3'b100
    } ev_kind_e;

    // one event taken from the pins
    typedef struct packed {
        ev_kind_e kind;
        logic     data;
    } chain_ev_s;

    // synchronised level inputs
    typedef struct packed {
        logic blank_n;
        logic light_all;
    } out_ctl_s;

endpackage : vfd_pkg

// ===== rtl/event_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module event_buffer #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 2
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // index step with wrap
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : step

    // handshakes and honest flags
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // next pointers and fill count
    always_comb begin
        wr_d  = push ? step(wr_q) : wr_q;
        rd_d  = pop ? step(rd_q) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // pointer registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage, written by index
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule : event_buffer

`default_nettype wire

// ===== verif/vfd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "vfd_defs.svh"

module vfd_host_model (
    input  wire logic core_clk,
    output var logic  serial_clk,
    output var logic  serial_in,
    output var logic  latch_strobe
);
    // 80 ns pin pulses at 200 MHz
    localparam int PULSE = 16;

    // pins start low
    initial begin
        serial_clk   = 1'b0;
        serial_in    = 1'b0;
        latch_strobe = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
    endtask : hold

    // one serial clock pulse; data line flips once its hold time is over
    task automatic pulse_clk(input logic bit_val);
        serial_in  <= bit_val;
        hold(PULSE);
        serial_clk <= 1'b1;
        hold(PULSE);
        serial_clk <= 1'b0;
        hold(PULSE);
        serial_in  <= ~bit_val;
        hold(1);
    endtask : pulse_clk

    // whole word, first bit ends in the last stage; strobe stays low
    task automatic shift_word(input logic [`CHAIN_LEN-1:0] w);
        for (int i = `CHAIN_LEN - 1; i >= 0; i--) begin
            pulse_clk(w[i]);
        end
    endtask : shift_word

    // strobe pulse only after the last shift edge
    task automatic load();
        latch_strobe <= 1'b1;
        hold(PULSE);
        latch_strobe <= 1'b0;
        hold(PULSE);
    endtask : load

    // clock edge taken with strobe high clears chain and latch
    task automatic clear();
        latch_strobe <= 1'b1;
        hold(PULSE);
        pulse_clk(1'b0);
        latch_strobe <= 1'b0;
        hold(PULSE);
    endtask : clear
endmodule : vfd_host_model

`default_nettype wire

// ===== verif/vfd_shift_latch_driver_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "vfd_defs.svh"

module vfd_shift_latch_driver_test;
    import vfd_pkg::*;
    localparam int           N   = `CHAIN_LEN;
    localparam logic [N-1:0] PAT = 60'h9a5_3c0f_f00d_bee1;
    logic         core_clk;
    logic         rst_n;
    logic         serial_clk;
    logic         serial_in;
    logic         latch_strobe;
    logic         blank_n;
    logic         light_all;
    logic         serial_out;
    logic [N-1:0] driver_output;
    int           err_count;
    int           checks;

    vfd_shift_latch_driver vfd_shift_latch_driver_i (
        .core_clk(core_clk), .rst_n(rst_n), .serial_clk(serial_clk), .serial_in(serial_in),
        .latch_strobe(latch_strobe), .blank_n(blank_n), .light_all(light_all),
        .serial_out(serial_out), .driver_output(driver_output));

    vfd_host_model vfd_host_model_i (
        .core_clk(core_clk), .serial_clk(serial_clk), .serial_in(serial_in),
        .latch_strobe(latch_strobe));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [N-1:0] seen, input logic [N-1:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // poll outputs at falling edges, bounded; a spent bound ends the run
    task automatic settle(input string what, input logic [N-1:0] exp_drv, input logic exp_so);
        int n;
        n = 0;
        while (n < 64) begin
            @(negedge core_clk);
            if (driver_output === exp_drv && serial_out === exp_so) break;
            n++;
        end
        check({what, " drivers"}, driver_output, exp_drv);
        check({what, " serial_out"}, {{(N-1){1'b0}}, serial_out}, {{(N-1){1'b0}}, exp_so});
        @(posedge core_clk);
        if (n >= 64) end_of_test();
    endtask : settle

    task automatic set_levels(input logic b, input logic l);
        blank_n   <= b;
        light_all <= l;
        @(posedge core_clk);
    endtask : set_levels

    // clear, load a word while blanked, then show it
    task automatic t_load();
        vfd_host_model_i.clear();
        vfd_host_model_i.shift_word(PAT);
        settle("blanked", '0, PAT[N-1]);
        vfd_host_model_i.load();
        set_levels(1'b1, 1'b0);
        settle("loaded", PAT, PAT[N-1]);
        $display("test t_load done");
    endtask : t_load

    // one more shift moves the chain but not the latch
    task automatic t_hold();
        vfd_host_model_i.pulse_clk(1'b1);
        settle("held", PAT, PAT[N-2]);
        vfd_host_model_i.load();
        settle("reload", {PAT[N-2:0], 1'b1}, PAT[N-2]);
        $display("test t_hold done");
    endtask : t_hold

    // blanking beats light-all, light-all beats latch data
    task automatic t_levels();
        set_levels(1'b0, 1'b1);
        settle("blank", '0, PAT[N-2]);
        set_levels(1'b1, 1'b1);
        settle("all on", '1, PAT[N-2]);
        set_levels(1'b1, 1'b0);
        settle("follow", {PAT[N-2:0], 1'b1}, PAT[N-2]);
        $display("test t_levels done");
    endtask : t_levels

    // clearing edge empties latch and serial output while shown
    task automatic t_clear();
        vfd_host_model_i.pulse_clk(1'b1);
        vfd_host_model_i.pulse_clk(1'b1);
        settle("shifted", {PAT[N-2:0], 1'b1}, PAT[N-4]);
        vfd_host_model_i.clear();
        settle("cleared", '0, 1'b0);
        $display("test t_clear done");
    endtask : t_clear

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // reset, then the scenarios in order
    initial begin
        rst_n     = 1'b0;
        blank_n   = 1'b0;
        light_all = 1'b0;
        err_count = 0;
        checks    = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_load();
        t_hold();
        t_levels();
        t_clear();
        end_of_test();
    end
endmodule : vfd_shift_latch_driver_test

`default_nettype wire
